// ### verilog/phymr_regs.vh
// Register map, field positions, reset values and timing counts of the transceiver management block
`ifndef PHYMR_REGS_VH
`define PHYMR_REGS_VH
`define PHYMR_REG_CONTROL 5'h00
`define PHYMR_REG_STATUS 5'h01
`define PHYMR_REG_ID_HIGH 5'h02
`define PHYMR_REG_ID_LOW 5'h03
`define PHYMR_REG_ADVERT 5'h04
`define PHYMR_CTL_RESET 15
`define PHYMR_CTL_LOOPBACK 14
`define PHYMR_CTL_SPEED 13
`define PHYMR_CTL_AN_ENABLE 12
`define PHYMR_CTL_POWER_DOWN 11
`define PHYMR_CTL_ISOLATE 10
`define PHYMR_CTL_AN_RESTART 9
`define PHYMR_CTL_DUPLEX 8
`define PHYMR_CTL_COL_TEST 7
`define PHYMR_CONTROL_RESET 16'h3400
`define PHYMR_CONTROL_WMASK 16'hFF80
`define PHYMR_ST_COMPLETE 5
`define PHYMR_ST_REM_FAULT 4
`define PHYMR_ST_LINK 2
`define PHYMR_ST_BABBLE 1
`define PHYMR_STATUS_FIXED 16'h7809
`define PHYMR_ADV_RF 13
`define PHYMR_ADVERT_RESET 16'h01E1
`define PHYMR_ADVERT_WMASK 16'hA1E1
`define PHYMR_RESET_TIME_US 50000
`define PHYMR_CLK_MHZ 200
`define PHYMR_RESET_CYCLES (`PHYMR_RESET_TIME_US * `PHYMR_CLK_MHZ)
`define PHYMR_ST_IDLE 2'h0
`define PHYMR_ST_HEAD 2'h1
`define PHYMR_ST_READ 2'h2
`define PHYMR_ST_WRITE 2'h3
`endif

// ### verilog/phymr_sync.v
// Two-flop synchroniser for one level from outside the core clock domain
`timescale 1ns/1ps
module phymr_sync
(
  input wire clk,
  input wire resetn,
  input wire din,
  output reg dout
);
  reg stage_q;
  always @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      stage_q <= 1'b0;
      dout <= 1'b0;
    end
    else
    begin
      stage_q <= din;
      dout <= stage_q;
    end
  end
endmodule // phymr_sync

// ### verilog/phymr_top.v
// Transceiver management registers behind the serial management port
`timescale 1ns/1ps
`include "phymr_regs.vh"
module phymr_top
#(
  parameter [4:0] PHY_ADDRESS = 5'h00,
  parameter [15:0] ID_HIGH = 16'h1234,
  parameter [15:0] ID_LOW = 16'h5670,
  parameter [31:0] RESET_CYCLES = `PHYMR_RESET_CYCLES
)
(
  input wire CORE_CLK,
  input wire RESETN,
  input wire MDC,
  input wire MDIO_IN,
  output reg MDIO_OUT,
  output reg MDIO_OE,
  input wire REMOTE_FAULT_IN,
  input wire LINK_OK_IN,
  input wire BABBLE_IN,
  input wire AN_DONE_IN,
  output reg LOOPBACK_SELECT,
  output reg POWER_DOWN_SELECT,
  output reg ISOLATE_DATA_PATH,
  output reg COLLISION_SIGNAL_TEST,
  output reg LINK_SPEED_100,
  output reg LINK_FULL_DUPLEX,
  output reg AUTONEG_START,
  output reg REMOTE_FAULT_ADVERTISE,
  output reg [15:0] ADVERT_WORD,
  output reg RESET_ACTIVE
);
  // =====================================================================
  // Input synchronisers
  wire mdc_s;
  wire mdio_s;
  wire rf_s;
  wire link_s;
  wire babble_s;
  wire an_done_s;
  wire [5:0] raw_in;
  wire [5:0] sync_out;
  assign raw_in = {MDC, MDIO_IN, REMOTE_FAULT_IN, LINK_OK_IN, BABBLE_IN, AN_DONE_IN};
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1)
    begin : g_sync
      phymr_sync u_sync
      (
        .clk(CORE_CLK),
        .resetn(RESETN),
        .din(raw_in[gi]),
        .dout(sync_out[gi])
      );
    end
  endgenerate
  assign {mdc_s, mdio_s, rf_s, link_s, babble_s, an_done_s} = sync_out;

  // =====================================================================
  // Clock edge detection
  reg mdc_prev_q;
  wire mdc_rise;
  wire mdc_fall;
  assign mdc_rise = mdc_s & ~mdc_prev_q;
  assign mdc_fall = ~mdc_s & mdc_prev_q;

  // =====================================================================
  // Register state
  reg [15:0] control_q;
  reg [15:0] advert_q;
  reg rem_fault_q;
  reg link_low_q;
  reg babble_q;
  reg an_pending_q;
  reg [31:0] rst_cnt_q;
  wire an_en;
  wire resetting;
  assign an_en = control_q[`PHYMR_CTL_AN_ENABLE];
  assign resetting = control_q[`PHYMR_CTL_RESET];

  // =====================================================================
  // Management frame engine
  reg [1:0] state_q;
  reg [5:0] cnt_q;
  reg [31:0] pre_q;
  reg [13:0] head_q;
  reg [15:0] shift_q;
  reg [4:0] reg_sel_q;
  reg status_read_q;
  reg wr_strobe_q;
  reg [15:0] wr_data_q;
  wire [31:0] pre_next;
  assign pre_next = {pre_q[30:0], mdio_s};
  wire start_seen;
  assign start_seen = (pre_q == 32'hFFFF_FFFF) & ~mdio_s;
  // Header including the bit sampled at this edge: st(1) op(2) phy(5) reg(5)
  wire [13:0] head_next;
  assign head_next = {head_q[12:0], mdio_s};

  wire [15:0] status_word;
  assign status_word = `PHYMR_STATUS_FIXED
    | ({15'h0000, an_en & an_done_s & ~an_pending_q} << `PHYMR_ST_COMPLETE)
    | ({15'h0000, rem_fault_q} << `PHYMR_ST_REM_FAULT)
    | ({15'h0000, link_s & ~link_low_q} << `PHYMR_ST_LINK)
    | ({15'h0000, babble_q} << `PHYMR_ST_BABBLE);

  reg [15:0] read_word;
  always @*
  begin
    read_word = 16'h0000;
    case (head_next[4:0])
      `PHYMR_REG_CONTROL: read_word = control_q;
      `PHYMR_REG_STATUS: read_word = status_word;
      `PHYMR_REG_ID_HIGH: read_word = ID_HIGH;
      `PHYMR_REG_ID_LOW: read_word = ID_LOW;
      `PHYMR_REG_ADVERT: read_word = advert_q;
      default: read_word = 16'h0000;
    endcase
  end

  // Frame header bits after start: op(2) phy(5) reg(5) = 12, then turnaround
  always @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      mdc_prev_q <= 1'b0;
      state_q <= `PHYMR_ST_IDLE;
      cnt_q <= 6'h00;
      pre_q <= 32'h0000_0000;
      head_q <= 14'h0000;
      shift_q <= 16'h0000;
      reg_sel_q <= 5'h00;
      status_read_q <= 1'b0;
      wr_strobe_q <= 1'b0;
      wr_data_q <= 16'h0000;
      MDIO_OUT <= 1'b0;
      MDIO_OE <= 1'b0;
    end
    else
    begin
      mdc_prev_q <= mdc_s;
      wr_strobe_q <= 1'b0;
      status_read_q <= 1'b0;
      if (mdc_rise)
      begin
        pre_q <= pre_next;
      end
      case (state_q)
        `PHYMR_ST_IDLE:
        begin
          MDIO_OE <= 1'b0;
          if (mdc_rise && start_seen)
          begin
            state_q <= `PHYMR_ST_HEAD;
            cnt_q <= 6'h00;
          end
        end
        `PHYMR_ST_HEAD:
        begin
          if (mdc_rise)
          begin
            head_q <= head_next;
            cnt_q <= cnt_q + 6'h01;
            if (cnt_q == 6'd12)
            begin
              // Second start bit, opcode, addresses collected; now first turnaround bit
              pre_q <= 32'h0000_0000;
              reg_sel_q <= head_next[4:0];
              if (head_next[9:5] != PHY_ADDRESS)
                state_q <= `PHYMR_ST_IDLE;
              else if (head_next[11:10] == 2'b10)
              begin
                // Read: release line in first turnaround bit
                state_q <= `PHYMR_ST_READ;
                shift_q <= read_word;
                status_read_q <= (head_next[4:0] == `PHYMR_REG_STATUS);
                cnt_q <= 6'h00;
              end
              else if (head_next[11:10] == 2'b01)
              begin
                state_q <= `PHYMR_ST_WRITE;
                cnt_q <= 6'h00;
              end
              else
                state_q <= `PHYMR_ST_IDLE;
            end
          end
        end
        `PHYMR_ST_READ:
        begin
          if (mdc_fall)
          begin
            cnt_q <= cnt_q + 6'h01;
            // First fall opens turnaround bit one: line stays released
            if (cnt_q == 6'd0)
            begin
              MDIO_OE <= 1'b0;
            end
            else if (cnt_q == 6'd1)
            begin
              MDIO_OE <= 1'b1;
              MDIO_OUT <= 1'b0;
            end
            else if (cnt_q <= 6'd17)
            begin
              MDIO_OUT <= shift_q[15];
              shift_q <= {shift_q[14:0], 1'b0};
            end
            else
            begin
              MDIO_OE <= 1'b0;
              state_q <= `PHYMR_ST_IDLE;
            end
          end
        end
        `PHYMR_ST_WRITE:
        begin
          if (mdc_rise)
          begin
            cnt_q <= cnt_q + 6'h01;
            shift_q <= {shift_q[14:0], mdio_s};
            if (cnt_q == 6'd17)
            begin
              wr_strobe_q <= 1'b1;
              wr_data_q <= {shift_q[14:0], mdio_s};
              state_q <= `PHYMR_ST_IDLE;
            end
          end
        end
        default: state_q <= `PHYMR_ST_IDLE;
      endcase
    end
  end

  // =====================================================================
  // Register file
  wire wr_control;
  wire wr_advert;
  assign wr_control = wr_strobe_q & (reg_sel_q == `PHYMR_REG_CONTROL) & ~resetting;
  assign wr_advert = wr_strobe_q & (reg_sel_q == `PHYMR_REG_ADVERT);
  wire rst_done;
  assign rst_done = resetting & (rst_cnt_q == RESET_CYCLES - 32'd1);

  always @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      control_q <= `PHYMR_CONTROL_RESET;
      advert_q <= `PHYMR_ADVERT_RESET;
      rem_fault_q <= 1'b0;
      link_low_q <= 1'b1;
      babble_q <= 1'b0;
      an_pending_q <= 1'b0;
      rst_cnt_q <= 32'h0000_0000;
    end
    else if (rst_done)
    begin
      // Soft reset finished; identifiers are parameters and stay put
      control_q <= `PHYMR_CONTROL_RESET;
      advert_q <= `PHYMR_ADVERT_RESET;
      rem_fault_q <= 1'b0;
      link_low_q <= 1'b1;
      babble_q <= 1'b0;
      an_pending_q <= 1'b0;
      rst_cnt_q <= 32'h0000_0000;
    end
    else
    begin
      rst_cnt_q <= resetting ? rst_cnt_q + 32'd1 : 32'h0000_0000;
      if (wr_control)
        control_q <= wr_data_q & `PHYMR_CONTROL_WMASK;
      // Restart reads zero when negotiation is off, clears once started
      if (wr_control && !wr_data_q[`PHYMR_CTL_AN_ENABLE])
        control_q[`PHYMR_CTL_AN_RESTART] <= 1'b0;
      else if (!wr_control && (!an_en || AUTONEG_START))
        control_q[`PHYMR_CTL_AN_RESTART] <= 1'b0;
      if (wr_advert)
        advert_q <= wr_data_q & `PHYMR_ADVERT_WMASK;
      if (AUTONEG_START)
        an_pending_q <= 1'b1;
      else if (!an_done_s)
        an_pending_q <= 1'b0;
      // Event set wins over the clear that follows a status read
      if (rf_s)
        rem_fault_q <= 1'b1;
      else if (status_read_q)
        rem_fault_q <= 1'b0;
      if (!link_s)
        link_low_q <= 1'b1;
      else if (status_read_q)
        link_low_q <= 1'b0;
      if (babble_s && !LINK_SPEED_100)
        babble_q <= 1'b1;
      else if (status_read_q || LINK_SPEED_100)
        babble_q <= 1'b0;
    end
  end

  // =====================================================================
  // Registered outputs toward the datapath
  always @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      LOOPBACK_SELECT <= 1'b0;
      POWER_DOWN_SELECT <= 1'b0;
      ISOLATE_DATA_PATH <= 1'b1;
      COLLISION_SIGNAL_TEST <= 1'b0;
      LINK_SPEED_100 <= 1'b1;
      LINK_FULL_DUPLEX <= 1'b0;
      AUTONEG_START <= 1'b0;
      REMOTE_FAULT_ADVERTISE <= 1'b0;
      ADVERT_WORD <= `PHYMR_ADVERT_RESET;
      RESET_ACTIVE <= 1'b0;
    end
    else
    begin
      LOOPBACK_SELECT <= control_q[`PHYMR_CTL_LOOPBACK];
      POWER_DOWN_SELECT <= control_q[`PHYMR_CTL_POWER_DOWN];
      ISOLATE_DATA_PATH <= control_q[`PHYMR_CTL_ISOLATE] | resetting;
      COLLISION_SIGNAL_TEST <= control_q[`PHYMR_CTL_COL_TEST];
      // Negotiated result comes from the datapath when enabled, these then both read 1; otherwise they carry manual choice
      LINK_SPEED_100 <= an_en ? 1'b1 : control_q[`PHYMR_CTL_SPEED];
      LINK_FULL_DUPLEX <= an_en ? 1'b1 : control_q[`PHYMR_CTL_DUPLEX];
      AUTONEG_START <= an_en & control_q[`PHYMR_CTL_AN_RESTART] & ~AUTONEG_START;
      REMOTE_FAULT_ADVERTISE <= advert_q[`PHYMR_ADV_RF];
      ADVERT_WORD <= advert_q;
      RESET_ACTIVE <= resetting;
    end
  end
endmodule // phymr_top

// ### testbench/phymr_props.sv
// Concurrent checks on the management register block ports
`timescale 1ns/1ps
module phymr_props
#(
  parameter [31:0] RESET_CYCLES = 32'h0000_0032
)
(
  input wire CORE_CLK,
  input wire RESETN,
  input wire MDC,
  input wire MDIO_IN,
  input wire MDIO_OUT,
  input wire MDIO_OE,
  input wire REMOTE_FAULT_IN,
  input wire LINK_OK_IN,
  input wire BABBLE_IN,
  input wire AN_DONE_IN,
  input wire LOOPBACK_SELECT,
  input wire POWER_DOWN_SELECT,
  input wire ISOLATE_DATA_PATH,
  input wire COLLISION_SIGNAL_TEST,
  input wire LINK_SPEED_100,
  input wire LINK_FULL_DUPLEX,
  input wire AUTONEG_START,
  input wire REMOTE_FAULT_ADVERTISE,
  input wire [15:0] ADVERT_WORD,
  input wire RESET_ACTIVE
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RESETN);
  logic [31:0] busy_q;
  // Counts how long the soft reset flag has been standing
  always @(posedge CORE_CLK or negedge RESETN)
  begin
    if (!RESETN)
      busy_q <= '0;
    else
      busy_q <= RESET_ACTIVE ? busy_q + 32'h0000_0001 : '0;
  end
  sequence s_defaults;
    ##[0:2] (ISOLATE_DATA_PATH && LINK_SPEED_100 && !LOOPBACK_SELECT && ADVERT_WORD == 16'h01E1);
  endsequence
  sequence s_drive;
    MDIO_OE[*8];
  endsequence
  chk_hw_isolate: assert property ($rose(RESETN) |-> ISOLATE_DATA_PATH)
    else $error("not isolated after reset");
  chk_soft_defaults: assert property ($fell(RESET_ACTIVE) |-> s_defaults)
    else $error("defaults missing after soft reset");
  chk_reset_length: assert property ($fell(RESET_ACTIVE) |->
    busy_q + 32'h0000_0002 >= RESET_CYCLES && busy_q <= RESET_CYCLES + 32'h0000_0002)
    else $error("soft reset length wrong");
  chk_ta_zero: assert property ($rose(MDIO_OE) |-> (!MDIO_OUT throughout s_drive))
    else $error("turnaround bit not zero");
  chk_start_pulse: assert property (AUTONEG_START |=> !AUTONEG_START)
    else $error("restart pulse too long");
  chk_an_forces: assert property (AUTONEG_START |-> ##[0:2] (LINK_SPEED_100 && LINK_FULL_DUPLEX))
    else $error("manual mode kept under negotiation");
  chk_rf_advert: assert property (REMOTE_FAULT_ADVERTISE == ADVERT_WORD[13])
    else $error("remote fault advert mismatch");
  chk_advert_mask: assert property ((ADVERT_WORD & ~16'hA1E1) == 16'h0000)
    else $error("unsupported advert bit set");
  chk_writes_held: assert property (RESET_ACTIVE && $past(RESET_ACTIVE, 3) |->
    $stable(LOOPBACK_SELECT) && $stable(ISOLATE_DATA_PATH) && $stable(POWER_DOWN_SELECT))
    else $error("control changed during reset");
endmodule // phymr_props
bind phymr_top phymr_props #(.RESET_CYCLES(RESET_CYCLES)) i_props (.*);

// ### testbench/phymr_station.sv
// Management station model that bit-bangs serial frames
`timescale 1ns/1ps
module phymr_station
(
  output logic mdc,
  output logic mdo,
  output logic mdo_en,
  input wire logic mdio
);
  initial
  begin
    mdc = 1'b0;
    mdo = 1'b1;
    mdo_en = 1'b0;
  end
  // Link clock stands low between frames
  task automatic bit_t(input logic d, output logic s);
    mdo = d;
    #62.5 mdc = 1'b1;
    s = mdio;
    #62.5 mdc = 1'b0;
  endtask
  task automatic frame(input logic rd, input logic [4:0] pa, input logic [4:0] ra,
    input logic [15:0] wd, output logic [17:0] rv);
    logic [45:0] h;
    logic s;
    h = {32'hFFFF_FFFF, 2'b01, rd, !rd, pa, ra};
    #0.7 mdo_en = 1'b1;
    for (int i = 45; i >= 0; i--)
      bit_t(h[i], s);
    // Read: release for the whole turnaround and data
    mdo_en = !rd;
    for (int i = 17; i >= 0; i--)
    begin
      bit_t(i == 17 ? 1'b1 : (i == 16 ? 1'b0 : wd[i]), s);
      rv[i] = s;
    end
    mdo_en = 1'b0;
  endtask
endmodule // phymr_station

// ### testbench/phy_management_registers_test.sv
// Self-checking bench for the management register block
`timescale 1ns/1ps
`include "phymr_regs.vh"
module phy_management_registers_test;
  // Identifier values are arbitrary
  localparam [15:0] ID_H = 16'hA5C3;
  localparam [15:0] ID_L = 16'h3C50;
  integer failures = 0;
  integer total_checks = 0;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic rfi = 1'b0, lnk = 1'b0, bab = 1'b0, andone = 1'b0;
  logic [3:0] starts = 4'h0;
  wire mdc, mdo, mdo_en, mo, moe, lb, pd, iso, ct, spd, fdx, ans, rfa, rsta;
  wire [15:0] adv;
  // Pull-up on the shared data line
  wire mdio = moe ? mo : (mdo_en ? mdo : 1'b1);
  always #2.5 clk = ~clk;
  always @(posedge clk)
    if (ans === 1'b1)
      starts <= starts + 4'h1;
  phymr_station i_sta (.mdc(mdc), .mdo(mdo), .mdo_en(mdo_en), .mdio(mdio));
  phymr_top #(.ID_HIGH(ID_H), .ID_LOW(ID_L), .RESET_CYCLES(32'h0000_1770)) i_dut
  (
    .CORE_CLK(clk), .RESETN(rstn), .MDC(mdc), .MDIO_IN(mdio), .MDIO_OUT(mo), .MDIO_OE(moe),
    .REMOTE_FAULT_IN(rfi), .LINK_OK_IN(lnk), .BABBLE_IN(bab), .AN_DONE_IN(andone),
    .LOOPBACK_SELECT(lb), .POWER_DOWN_SELECT(pd), .ISOLATE_DATA_PATH(iso),
    .COLLISION_SIGNAL_TEST(ct), .LINK_SPEED_100(spd), .LINK_FULL_DUPLEX(fdx),
    .AUTONEG_START(ans), .REMOTE_FAULT_ADVERTISE(rfa), .ADVERT_WORD(adv), .RESET_ACTIVE(rsta)
  );
  task automatic final_report;
    if (failures == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp(input logic [17:0] g, input logic [17:0] e);
    total_checks++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic gap(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    logic [17:0] v;
    i_sta.frame(1'b0, 5'h00, ra, d, v);
    gap(6);
  endtask
  // Turnaround reads released one, then driven zero
  task automatic rdc(input logic [4:0] ra, input logic [15:0] e);
    logic [17:0] v;
    i_sta.frame(1'b1, 5'h00, ra, 16'h0000, v);
    cmp(v, {2'b10, e});
  endtask
  task automatic t_defaults;
    logic [17:0] v;
    rdc(`PHYMR_REG_CONTROL, 16'h3400);
    rdc(`PHYMR_REG_STATUS, 16'h7809);
    rdc(`PHYMR_REG_ID_HIGH, ID_H);
    rdc(`PHYMR_REG_ID_LOW, ID_L);
    rdc(`PHYMR_REG_ADVERT, 16'h01E1);
    rdc(5'h05, 16'h0000);
    i_sta.frame(1'b1, 5'h01, 5'h00, 16'h0000, v);
    cmp(v, 18'h3_FFFF);
    cmp(iso, 1'b1);
  endtask
  task automatic t_manual;
    wr(`PHYMR_REG_CONTROL, 16'h4180);
    cmp({lb, ct, iso, spd, fdx, pd}, 6'b110010);
    rdc(`PHYMR_REG_CONTROL, 16'h4180);
    wr(`PHYMR_REG_CONTROL, 16'h2A00);
    cmp({pd, spd, fdx}, 3'b110);
    rdc(`PHYMR_REG_CONTROL, 16'h2800);
  endtask
  task automatic t_latch;
    wr(`PHYMR_REG_CONTROL, 16'h0000);
    @(posedge clk) lnk <= 1'b1;
    rdc(`PHYMR_REG_STATUS, 16'h7809);
    rdc(`PHYMR_REG_STATUS, 16'h780D);
    @(posedge clk) {rfi, bab, lnk} <= 3'b110;
    gap(20);
    @(posedge clk) {rfi, bab, lnk} <= 3'b001;
    rdc(`PHYMR_REG_STATUS, 16'h781B);
    rdc(`PHYMR_REG_STATUS, 16'h780D);
  endtask
  task automatic t_autoneg;
    wr(`PHYMR_REG_CONTROL, 16'h3300);
    cmp({spd, fdx, starts}, 6'b110001);
    rdc(`PHYMR_REG_CONTROL, 16'h3100);
    rdc(`PHYMR_REG_STATUS, 16'h780D);
    @(posedge clk) {andone, bab} <= 2'b11;
    gap(20);
    @(posedge clk) bab <= 1'b0;
    rdc(`PHYMR_REG_STATUS, 16'h782D);
  endtask
  task automatic t_advert;
    wr(`PHYMR_REG_ADVERT, 16'hFFFF);
    rdc(`PHYMR_REG_ADVERT, 16'hA1E1);
    cmp({rfa, adv}, 17'h1_A1E1);
  endtask
  task automatic t_soft_reset;
    wr(`PHYMR_REG_CONTROL, 16'hB100);
    cmp(rsta, 1'b1);
    rdc(`PHYMR_REG_CONTROL, 16'hB100);
    wr(`PHYMR_REG_CONTROL, 16'h4000);
    // Station holds off until the reset has run out
    for (int n = 0; n < 8000 && rsta !== 1'b0; n++)
      @(posedge clk);
    cmp(rsta, 1'b0);
    if (rsta !== 1'b0)
      final_report;
    gap(4);
    rdc(`PHYMR_REG_CONTROL, 16'h3400);
    rdc(`PHYMR_REG_ADVERT, 16'h01E1);
    rdc(`PHYMR_REG_ID_LOW, ID_L);
    cmp({iso, lb}, 2'b10);
  endtask
  initial
  begin
    gap(5);
    rstn <= 1'b1;
    gap(10);
    t_defaults;
    t_manual;
    t_latch;
    t_autoneg;
    t_advert;
    t_soft_reset;
    final_report;
  end
endmodule // phy_management_registers_test
